// file: verilog/tif_irq.v
// timer and external interrupt flags, priority and entry/return sequencer
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tif_map.vh"

module tif_irq #(
  parameter AW = 12
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata_r,
  output reg           pready_r,
  output reg           pslverr_r,
  input  wire          wide_ovf_evt,
  input  wire          cmp_match_evt,
  input  wire          capture_evt,
  input  wire          narrow_ovf_evt,
  input  wire          external_irq_pin_zero,
  input  wire          external_irq_pin_one,
  input  wire          cpu_instr_done,
  input  wire          cpu_return_from_interrupt,
  output reg           cpu_hold_r,
  output reg           pc_push_r,
  output reg           pc_pop_r,
  output reg           vector_exec_r,
  output reg  [3:0]    vector_r,
  output reg           global_irq_enable_r,
  output reg           sleep_enable_r,
  output reg           sleep_mode_select_r
);

  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_ENTRY = 4'h2;
  localparam [3:0] ST_JUMP  = 4'h4;
  localparam [3:0] ST_RET   = 4'h8;

  // edge or level test for one synchronised pin
  function ext_hit;
    input [1:0] sense;
    input       now;
    input       prev;
    begin
      case (sense)
        `TIF_SENSE_LOW:  ext_hit = ~now;
        `TIF_SENSE_ANY:  ext_hit = now ^ prev;
        `TIF_SENSE_FALL: ext_hit = prev & ~now;
        default:         ext_hit = now & ~prev;
      endcase
    end
  endfunction

  reg  [7:0] mcu_control_r;
  reg  [7:0] timer_flags_r;
  reg  [7:0] timer_mask_r;
  reg  [7:0] ext_flags_r;
  reg  [7:0] ext_mask_r;
  reg  [1:0] pin0_sync_r;
  reg  [1:0] pin1_sync_r;
  reg        pin0_prev_r;
  reg        pin1_prev_r;
  reg  [3:0] state_r;
  reg  [1:0] cnt_r;
  reg        after_ret_r;
  reg  [7:0] timer_flags_nxt;
  reg  [7:0] ext_flags_nxt;
  reg  [3:0] pick_nxt;
  reg  [7:0] rd_nxt;
  reg        map_nxt;

  wire [7:0] idx      = paddr[9:2];
  wire       setup    = psel & ~penable;
  wire       wr_done  = psel & penable & pready_r & pwrite;
  wire       in_range = (paddr[AW-1:10] == {(AW-10){1'b0}}) & (paddr[1:0] == 2'h0);
  wire [1:0] sense0   = mcu_control_r[1:0];
  wire [1:0] sense1   = mcu_control_r[3:2];
  // pin level is read regardless of pin direction, so software can drive it
  wire       hit0     = ext_hit(sense0, pin0_sync_r[1], pin0_prev_r);
  wire       hit1     = ext_hit(sense1, pin1_sync_r[1], pin1_prev_r);
  wire       lvl0     = (sense0 == `TIF_SENSE_LOW);
  wire       lvl1     = (sense1 == `TIF_SENSE_LOW);
  wire       req_ext0 = ext_mask_r[`TIF_BIT_EXT0] & (lvl0 ? hit0 : ext_flags_r[`TIF_BIT_EXT0]);
  wire       req_ext1 = ext_mask_r[`TIF_BIT_EXT1] & (lvl1 ? hit1 : ext_flags_r[`TIF_BIT_EXT1]);
  wire [7:0] timer_req = timer_flags_r & timer_mask_r;
  // no service in the first boundary after a return
  wire       may_take = global_irq_enable_r & cpu_instr_done & ~after_ret_r;
  wire       wr_now   = wr_done & in_range;
  wire       sw_gie   = wr_now & (idx == `TIF_IDX_CPU_STATUS);

  // lowest vector address wins
  always @* begin
    if (req_ext0) begin
      pick_nxt = `TIF_VEC_EXT0;
    end else if (req_ext1) begin
      pick_nxt = `TIF_VEC_EXT1;
    end else if (timer_req[`TIF_BIT_CAP]) begin
      pick_nxt = `TIF_VEC_CAP;
    end else if (timer_req[`TIF_BIT_CMP]) begin
      pick_nxt = `TIF_VEC_CMP;
    end else if (timer_req[`TIF_BIT_WIDE_OVF]) begin
      pick_nxt = `TIF_VEC_WIDE_OVF;
    end else if (timer_req[`TIF_BIT_NARROW_OVF]) begin
      pick_nxt = `TIF_VEC_NARROW_OVF;
    end else begin
      pick_nxt = `TIF_VEC_NONE;
    end
  end

  // flag next values; a set in the clearing cycle wins
  always @* begin
    timer_flags_nxt = timer_flags_r;
    ext_flags_nxt   = ext_flags_r;
    if (wr_now && idx == `TIF_IDX_TIMER_FLAGS) begin
      timer_flags_nxt = timer_flags_nxt & ~pwdata[7:0];
    end
    if (wr_now && idx == `TIF_IDX_EXT_FLAGS) begin
      ext_flags_nxt = ext_flags_nxt & ~pwdata[7:0];
    end
    if (state_r == ST_ENTRY && cnt_r == `TIF_ENTRY_CYCLES) begin
      case (vector_r)
        `TIF_VEC_EXT0:       ext_flags_nxt[`TIF_BIT_EXT0] = 1'b0;
        `TIF_VEC_EXT1:       ext_flags_nxt[`TIF_BIT_EXT1] = 1'b0;
        `TIF_VEC_CAP:        timer_flags_nxt[`TIF_BIT_CAP] = 1'b0;
        `TIF_VEC_CMP:        timer_flags_nxt[`TIF_BIT_CMP] = 1'b0;
        `TIF_VEC_WIDE_OVF:   timer_flags_nxt[`TIF_BIT_WIDE_OVF] = 1'b0;
        `TIF_VEC_NARROW_OVF: timer_flags_nxt[`TIF_BIT_NARROW_OVF] = 1'b0;
        default:             timer_flags_nxt = timer_flags_nxt;
      endcase
    end
    // overflow source also covers the pwm step away from zero
    if (wide_ovf_evt) begin
      timer_flags_nxt[`TIF_BIT_WIDE_OVF] = 1'b1;
    end
    if (cmp_match_evt) begin
      timer_flags_nxt[`TIF_BIT_CMP] = 1'b1;
    end
    if (capture_evt) begin
      timer_flags_nxt[`TIF_BIT_CAP] = 1'b1;
    end
    if (narrow_ovf_evt) begin
      timer_flags_nxt[`TIF_BIT_NARROW_OVF] = 1'b1;
    end
    timer_flags_nxt = timer_flags_nxt & `TIF_TIMER_BITS_MASK;
    if (lvl0) begin
      ext_flags_nxt[`TIF_BIT_EXT0] = 1'b0;
    end else if (hit0) begin
      ext_flags_nxt[`TIF_BIT_EXT0] = 1'b1;
    end
    if (lvl1) begin
      ext_flags_nxt[`TIF_BIT_EXT1] = 1'b0;
    end else if (hit1) begin
      ext_flags_nxt[`TIF_BIT_EXT1] = 1'b1;
    end
    ext_flags_nxt = ext_flags_nxt & `TIF_EXT_BITS_MASK;
  end

  // read mux and address decode
  always @* begin
    rd_nxt  = 8'h00;
    map_nxt = in_range;
    if (idx == `TIF_IDX_MCU_CONTROL) begin
      rd_nxt = mcu_control_r & `TIF_MCU_CONTROL_MASK;
    end else if (idx == `TIF_IDX_TIMER_FLAGS) begin
      rd_nxt = timer_flags_r;
    end else if (idx == `TIF_IDX_TIMER_MASK) begin
      rd_nxt = timer_mask_r;
    end else if (idx == `TIF_IDX_EXT_FLAGS) begin
      rd_nxt = ext_flags_r;
    end else if (idx == `TIF_IDX_EXT_MASK) begin
      rd_nxt = ext_mask_r;
    end else if (idx == `TIF_IDX_CPU_STATUS) begin
      rd_nxt = {global_irq_enable_r, 7'h00};
    end else begin
      map_nxt = 1'b0;
    end
  end

  // apb slave: no wait state, answer in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        prdata_r  <= {24'h00_0000, rd_nxt};
        pslverr_r <= ~(map_nxt & in_range);
      end else if (pready_r) begin
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_control_r <= `TIF_RST_MCU_CONTROL;
      timer_mask_r  <= `TIF_RST_TIMER_MASK;
      sleep_enable_r      <= 1'b0;
      sleep_mode_select_r <= 1'b0;
      ext_mask_r    <= `TIF_RST_EXT_MASK;
    end else if (wr_now) begin
      if (idx == `TIF_IDX_MCU_CONTROL) begin
        mcu_control_r <= pwdata[7:0] & `TIF_MCU_CONTROL_MASK;
        // sleep fields mirrored to ports so they leave straight from a flop
        sleep_enable_r      <= pwdata[`TIF_BIT_SLEEP_EN];
        sleep_mode_select_r <= pwdata[`TIF_BIT_SLEEP_MODE];
      end else if (idx == `TIF_IDX_TIMER_MASK) begin
        timer_mask_r <= pwdata[7:0] & `TIF_TIMER_BITS_MASK;
      end else if (idx == `TIF_IDX_EXT_MASK) begin
        ext_mask_r <= pwdata[7:0] & `TIF_EXT_BITS_MASK;
      end
    end
  end

  // pins are asynchronous; prev is taken from the second stage only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_sync_r <= 2'h3;
      pin1_sync_r <= 2'h3;
      pin0_prev_r <= 1'b1;
      pin1_prev_r <= 1'b1;
    end else begin
      pin0_sync_r <= {pin0_sync_r[0], external_irq_pin_zero};
      pin1_sync_r <= {pin1_sync_r[0], external_irq_pin_one};
      pin0_prev_r <= pin0_sync_r[1];
      pin1_prev_r <= pin1_sync_r[1];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_flags_r <= `TIF_RST_TIMER_FLAGS;
      ext_flags_r   <= 8'h00;
    end else begin
      timer_flags_r <= timer_flags_nxt;
      ext_flags_r   <= ext_flags_nxt;
    end
  end

  // entry, jump and return sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r             <= ST_IDLE;
      cnt_r               <= 2'h0;
      vector_r            <= `TIF_VEC_NONE;
      vector_exec_r       <= 1'b0;
      pc_push_r           <= 1'b0;
      pc_pop_r            <= 1'b0;
      cpu_hold_r          <= 1'b0;
      after_ret_r         <= 1'b0;
      global_irq_enable_r <= 1'b0;
    end else begin
      vector_exec_r <= 1'b0;
      pc_push_r     <= 1'b0;
      pc_pop_r      <= 1'b0;
      if (sw_gie) begin
        global_irq_enable_r <= pwdata[`TIF_BIT_GIE];
      end
      case (state_r)
        ST_IDLE: begin
          if (cpu_instr_done) begin
            after_ret_r <= 1'b0;
          end
          if (cpu_return_from_interrupt) begin
            state_r    <= ST_RET;
            cnt_r      <= 2'h1;
            cpu_hold_r <= 1'b1;
            pc_pop_r   <= 1'b1;
          end else if (may_take && pick_nxt != `TIF_VEC_NONE) begin
            state_r             <= ST_ENTRY;
            cnt_r               <= 2'h1;
            vector_r            <= pick_nxt;
            cpu_hold_r          <= 1'b1;
            pc_push_r           <= 1'b1;
            global_irq_enable_r <= 1'b0;
          end
        end
        ST_ENTRY: begin
          cnt_r     <= cnt_r + 2'h1;
          pc_push_r <= (cnt_r == 2'h1);
          if (cnt_r == `TIF_ENTRY_CYCLES) begin
            state_r       <= ST_JUMP;
            cnt_r         <= 2'h0;
            vector_exec_r <= 1'b1;
          end
        end
        ST_JUMP: begin
          cnt_r <= cnt_r + 2'h1;
          if (cnt_r == {1'b0, `TIF_JUMP_CYCLES}) begin
            state_r    <= ST_IDLE;
            cnt_r      <= 2'h0;
            cpu_hold_r <= 1'b0;
          end
        end
        ST_RET: begin
          cnt_r    <= cnt_r + 2'h1;
          pc_pop_r <= (cnt_r == 2'h1);
          if (cnt_r == `TIF_RETURN_CYCLES) begin
            state_r             <= ST_IDLE;
            cnt_r               <= 2'h0;
            cpu_hold_r          <= 1'b0;
            after_ret_r         <= 1'b1;
            global_irq_enable_r <= 1'b1;
          end
        end
        default: begin
          state_r    <= ST_IDLE;
          cnt_r      <= 2'h0;
          cpu_hold_r <= 1'b0;
        end
      endcase
    end
  end

endmodule // tif_irq

// file: verilog/tif_map.vh
// register indices, field positions and timing counts of the interrupt flag block
`ifndef TIF_MAP_VH
`define TIF_MAP_VH
// register indices; byte address is four times the index
`define TIF_IDX_MCU_CONTROL  8'h35
`define TIF_IDX_TIMER_FLAGS  8'h38
`define TIF_IDX_TIMER_MASK   8'h39
`define TIF_IDX_EXT_FLAGS    8'h3a
`define TIF_IDX_EXT_MASK     8'h3b
`define TIF_IDX_CPU_STATUS   8'h3f
// reset values
`define TIF_RST_MCU_CONTROL  8'h00
`define TIF_RST_TIMER_FLAGS  8'h00
`define TIF_RST_TIMER_MASK   8'h00
`define TIF_RST_EXT_MASK     8'h00
// writable / implemented bit masks
`define TIF_MCU_CONTROL_MASK 8'h3f
`define TIF_TIMER_BITS_MASK  8'hca
`define TIF_EXT_BITS_MASK    8'hc0
// timer flag and enable bit positions
`define TIF_BIT_WIDE_OVF     7
`define TIF_BIT_CMP          6
`define TIF_BIT_CAP          3
`define TIF_BIT_NARROW_OVF   1
// external flag and enable bit positions
`define TIF_BIT_EXT1         7
`define TIF_BIT_EXT0         6
// control fields
`define TIF_BIT_SLEEP_EN     5
`define TIF_BIT_SLEEP_MODE   4
`define TIF_BIT_GIE          7
// sense codes
`define TIF_SENSE_LOW        2'h0
`define TIF_SENSE_ANY        2'h1
`define TIF_SENSE_FALL       2'h2
`define TIF_SENSE_RISE       2'h3
// vector addresses
`define TIF_VEC_NONE         4'h0
`define TIF_VEC_EXT0         4'h1
`define TIF_VEC_EXT1         4'h2
`define TIF_VEC_CAP          4'h3
`define TIF_VEC_CMP          4'h4
`define TIF_VEC_WIDE_OVF     4'h5
`define TIF_VEC_NARROW_OVF   4'h6
// sequence end counts; entry and return last that many clock cycles, the jump one more
`define TIF_ENTRY_CYCLES     2'h3
`define TIF_JUMP_CYCLES      1'h1
`define TIF_RETURN_CYCLES    2'h3
`endif

// file: testbench/tif_irq_properties.sv
// concurrent checks on the interrupt flag block ports
`timescale 1ns/1ps
module tif_irq_properties #(
  parameter AW = 12
) (
  input logic       pclk,
  input logic       presetn,
  input logic       psel,
  input logic       penable,
  input logic       pready_r,
  input logic       cpu_instr_done,
  input logic       cpu_hold_r,
  input logic       pc_push_r,
  input logic       pc_pop_r,
  input logic       vector_exec_r,
  input logic [3:0] vector_r,
  input logic       global_irq_enable_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_two_push;
    pc_push_r ##1 !pc_push_r;
  endsequence
  sequence s_two_pop;
    pc_pop_r ##1 !pc_pop_r;
  endsequence
  sequence s_jump;
    cpu_hold_r ##1 cpu_hold_r ##1 !cpu_hold_r;
  endsequence
  AST_PUSH_TWO: assert property ($rose(pc_push_r) |=> s_two_push)
    else $error("pc push not two cycles");
  AST_VEC_TIME: assert property ($rose(pc_push_r) |-> ##3 vector_exec_r && vector_r != 4'h0)
    else $error("vector not four cycles after take");
  AST_ENTRY_GIE_OFF: assert property ($rose(pc_push_r) |-> !global_irq_enable_r)
    else $error("global enable kept on entry");
  AST_NEED_GIE: assert property ($rose(pc_push_r) |-> $past(global_irq_enable_r))
    else $error("entry without global enable");
  AST_TAKE_BOUNDARY: assert property ($rose(pc_push_r) |-> $past(cpu_instr_done))
    else $error("entry inside an instruction");
  AST_JUMP: assert property (vector_exec_r |-> s_jump)
    else $error("vector jump not two cycles");
  AST_POP_TWO: assert property ($rose(pc_pop_r) |=> s_two_pop)
    else $error("pc pop not two cycles");
  AST_RET_GIE: assert property ($rose(pc_pop_r) |-> ##4 global_irq_enable_r && !cpu_hold_r)
    else $error("return not four cycles");
  AST_AFTER_RET: assert property ($rose(pc_pop_r) |-> ##3 !pc_push_r [*2])
    else $error("entry before one instruction after return");
  AST_PREADY: assert property (psel && !penable |=> pready_r)
    else $error("no ready in first access cycle");
endmodule // tif_irq_properties

// file: testbench/tif_cpu_model.sv
// behavioural cpu sequencer facing the interrupt flag block
`timescale 1ns/1ps
module tif_cpu_model (
  input  wire  pclk,
  input  wire  presetn,
  input  wire  cpu_hold_r,
  input  wire  slow,
  input  wire  ret_req,
  output logic cpu_instr_done,
  output logic cpu_return_from_interrupt
);
  logic [1:0] cnt_r;
  logic       pend_r;
  // slow: three-cycle instructions, boundary only on the last
  assign cpu_instr_done = !cpu_hold_r && cnt_r == 2'h0 && !cpu_return_from_interrupt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      pend_r <= 1'h0;
      cpu_return_from_interrupt <= 1'h0;
    end else begin
      cnt_r <= (cpu_hold_r || cnt_r == 2'h0) ? (slow ? 2'h2 : 2'h0) : cnt_r - 2'h1;
      // a return waits until the entry sequence has let go
      pend_r <= (pend_r || ret_req) && !cpu_return_from_interrupt;
      cpu_return_from_interrupt <= (pend_r || ret_req) && !cpu_hold_r && !cpu_return_from_interrupt;
    end
  end
endmodule // tif_cpu_model

// file: testbench/timer_ext_irq_flags_response_test.sv
// self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`include "tif_map.vh"
module timer_ext_irq_flags_response_test;
  logic        pclk, presetn, psel, penable, pwrite, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_r, rd_q;
  logic        pready_r, pslverr_r, cpu_hold_r, vector_exec_r, gie;
  logic [3:0]  vector_r, evts;
  logic        pin0, pin1, slow, ret_req, instr_done, return_from_interrupt;
  logic        sleep_en, sleep_mode;
  int          err_count, n_compared;

  tif_irq u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .wide_ovf_evt(evts[3]),
    .cmp_match_evt(evts[2]), .capture_evt(evts[1]), .narrow_ovf_evt(evts[0]),
    .external_irq_pin_zero(pin0), .external_irq_pin_one(pin1),
    .cpu_instr_done(instr_done), .cpu_return_from_interrupt(return_from_interrupt), .cpu_hold_r(cpu_hold_r),
    .pc_push_r(), .pc_pop_r(), .vector_exec_r(vector_exec_r),
    .vector_r(vector_r), .global_irq_enable_r(gie), .sleep_enable_r(sleep_en),
    .sleep_mode_select_r(sleep_mode));
  tif_cpu_model u_cpu (
    .pclk(pclk), .presetn(presetn), .cpu_hold_r(cpu_hold_r), .slow(slow),
    .ret_req(ret_req), .cpu_instr_done(instr_done), .cpu_return_from_interrupt(return_from_interrupt));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_r !== 1'h1 && k < 20);
    chk("pready", 32'h1, {31'h0, pready_r});
    rd_q = prdata_r;
    rd_err = pslverr_r;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [7:0] i, input logic [7:0] e);
    apb(1'h0, i, 8'h00);
    chk("rdata", {24'h0, e}, rd_q);
  endtask

  task pulse(input logic [3:0] m);
    @(posedge pclk);
    evts <= m;
    @(posedge pclk);
    evts <= 4'h0;
  endtask

  task wait_vec(input logic [3:0] v);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (vector_exec_r !== 1'h1 && k < 200);
    chk("vexec", 32'h1, {31'h0, vector_exec_r});
    chk("vector", {28'h0, v}, {28'h0, vector_r});
  endtask

  task ret;
    int k;
    k = 0;
    @(posedge pclk);
    ret_req <= 1'h1;
    @(posedge pclk);
    ret_req <= 1'h0;
    do begin
      @(posedge pclk);
      k++;
    end while (gie !== 1'h1 && k < 50);
    chk("gie", 32'h1, {31'h0, gie});
  endtask

  task quiet;
    int h;
    h = 0;
    repeat (12) begin
      @(posedge pclk);
      if (vector_exec_r === 1'h1) h++;
    end
    chk("quiet", 32'h0, h);
  endtask

  task t_regs;
    rd(`TIF_IDX_MCU_CONTROL, 8'h00);
    rd(`TIF_IDX_TIMER_FLAGS, 8'h00);
    apb(1'h1, `TIF_IDX_MCU_CONTROL, 8'hff);
    rd(`TIF_IDX_MCU_CONTROL, 8'h3f);
    chk("sleep", 32'h3, {30'h0, sleep_en, sleep_mode});
    apb(1'h0, 8'h00, 8'h00);
    chk("slverr", 32'h1, {31'h0, rd_err});
  endtask

  task t_w1c;
    logic [7:0] e;
    e = 8'hca;
    pulse(4'hf);
    // ones written to reserved places must clear nothing
    apb(1'h1, `TIF_IDX_TIMER_FLAGS, 8'h35);
    rd(`TIF_IDX_TIMER_FLAGS, e);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, `TIF_IDX_TIMER_FLAGS, e & (~e + 8'h01));
      e = e & (e - 8'h01);
      rd(`TIF_IDX_TIMER_FLAGS, e);
    end
  endtask

  task t_prio;
    slow <= 1'h1;
    apb(1'h1, `TIF_IDX_TIMER_MASK, 8'hca);
    pulse(4'hf);
    quiet;
    apb(1'h1, `TIF_IDX_CPU_STATUS, 8'h80);
    for (int v = 3; v < 7; v++) begin
      wait_vec(v[3:0]);
      ret;
    end
    rd(`TIF_IDX_TIMER_FLAGS, 8'h00);
    slow <= 1'h0;
  endtask

  task t_ext;
    apb(1'h1, `TIF_IDX_MCU_CONTROL, 8'h0e);
    apb(1'h1, `TIF_IDX_EXT_MASK, 8'hc0);
    pin0 <= 1'h0;
    wait_vec(4'h1);
    ret;
    pin1 <= 1'h0;
    quiet;
    pin1 <= 1'h1;
    wait_vec(4'h2);
    ret;
    apb(1'h1, `TIF_IDX_MCU_CONTROL, 8'h04);
    wait_vec(4'h1);
    ret;
    wait_vec(4'h1);
    pin0 <= 1'h1;
    pin1 <= 1'h0;
    repeat (6) @(posedge pclk);
    ret;
    wait_vec(4'h2);
    ret;
  endtask

  task results;
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    evts = 4'h0;
    pin0 = 1'h1;
    pin1 = 1'h1;
    slow = 1'h0;
    ret_req = 1'h0;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_w1c;
    t_prio;
    t_ext;
    results;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results;
  end
endmodule // timer_ext_irq_flags_response_test

bind tif_irq tif_irq_properties #(.AW(AW)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready_r(pready_r), .cpu_instr_done(cpu_instr_done), .cpu_hold_r(cpu_hold_r),
  .pc_push_r(pc_push_r), .pc_pop_r(pc_pop_r), .vector_exec_r(vector_exec_r),
  .vector_r(vector_r), .global_irq_enable_r(global_irq_enable_r));
